// ==== rtl/gauge_cal_map.svh ====
// register map, field positions and timing counts for the offset calibration sequencer
`ifndef GAUGE_CAL_MAP_SVH
`define GAUGE_CAL_MAP_SVH

`define CLOCK_HZ 50000000
`define ADDR_DEVICE_CONTROL 8'h00
`define ADDR_STATUS_FLAGS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0c
`define ADDR_CURRENT_AVG 8'h10
`define ADDR_CHARGE_LO 8'h14
`define ADDR_CHARGE_HI 8'h18
`define ADDR_OFFSET 8'h1c
`define ADDR_EXT_OFFSET 8'h20
`define ADDR_CAPACITY 8'h24
`define ADDR_TTE_BASE 8'h28
`define CTRL_QUICK_BIT 0
`define CTRL_EXT_MEAS_BIT 1
`define CTRL_RECAL_BIT 2
`define CTRL_RESET 8'h00
`define FLAG_CAL_BUSY_BIT 0
`define FLAG_SLEEP_BIT 1
`define FLAG_QUICK_DONE_BIT 2
`define IRQ_CAL_DONE_BIT 0
`define IRQ_SLEEP_BIT 1
`define IRQ_EXT_DONE_BIT 2
`define AVG_WINDOW_MS 5120
`define QUICK_MEAS_MS 1280
`define FULL_DEFER_MS 40000
`define SLEEP_LOW_MS 2
`define CAP_STEP_COUNTS 32'd357
`define TTE_DIV_SAMPLES 16'd60

`endif

// ==== rtl/gauge_cal_pkg.sv ====
// types shared by the offset calibration sequencer
package gauge_cal_pkg;
    typedef enum logic [2:0] {
        CAL_IDLE, CAL_SETTLE, CAL_QUICK, CAL_DEFER, CAL_FULL, CAL_EXT
    } cal_state_t;
    typedef logic signed [15:0] sample_t;
endpackage

// ==== rtl/sample_acc_if.sv ====
// accumulator control and result between the sequencer and the window accumulator
`timescale 1ns/100ps
interface sample_acc_if;
    logic start;
    logic signed [15:0] sample;
    logic done;
    logic signed [31:0] sum;
    modport master (output start, output sample, input done, input sum);
    modport acc (input start, input sample, output done, output sum);
endinterface

// ==== rtl/window_accumulator.sv ====
// sums samples over a window of a given length of ticks
`timescale 1ns/100ps
module window_accumulator (
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] window_ticks,
    sample_acc_if.acc acc
);
    logic [31:0] count_reg;
    logic signed [31:0] run_reg;
    logic busy_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            count_reg <= 32'h0;
            run_reg <= 32'sh0;
            busy_reg <= 1'b0;
            acc.done <= 1'b0;
            acc.sum <= 32'sh0;
        end else begin
            acc.done <= 1'b0;
            if (acc.start) begin
                count_reg <= 32'h1;
                run_reg <= 32'(acc.sample);
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (count_reg == window_ticks) begin
                    busy_reg <= 1'b0;
                    acc.done <= 1'b1;
                    acc.sum <= run_reg;
                end else begin
                    count_reg <= count_reg + 32'h1;
                    run_reg <= run_reg + 32'(acc.sample);
                end
            end
        end
    end
endmodule // window_accumulator

// ==== rtl/offset_cal_sequencer.sv ====
// charge integration, current averaging and offset calibration sequencing
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`include "gauge_cal_map.svh"

// Function
// - integrate sense voltage continuously into charge
// - current is 5.12 s average
// - capacity in 3.57 uVh steps
// - time-to-empty for four load cases
// - recalibrate offset when conditions change
// - in-progress flag set during calibration
// - freeze current and time-to-empty during calibration; charge and capacity keep running
// - quick calibration first, full deferred 40 s
// - discard first 1.28 s sample, keep second, unless the quick bit is written while settling
// - external offset measure command and compensation
// - lines held low enter sleep
module offset_cal_sequencer
    import gauge_cal_pkg::*;
#(
    parameter int unsigned WINDOW_TICKS = `CLOCK_HZ / 1000 * `AVG_WINDOW_MS,
    parameter int unsigned QUICK_TICKS = `CLOCK_HZ / 1000 * `QUICK_MEAS_MS,
    parameter int unsigned DEFER_TICKS = `CLOCK_HZ / 1000 * `FULL_DEFER_MS,
    parameter int unsigned SLEEP_TICKS = `CLOCK_HZ / 1000 * `SLEEP_LOW_MS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    input wire logic [15:0] sense_sample,
    input wire logic sample_valid,
    input wire logic [7:0] load_class,
    input wire logic [15:0] standby_current,
    input wire logic [15:0] peak_current,
    input wire logic [15:0] at_rate_current,
    input wire logic comm_line_a,
    input wire logic comm_line_b,
    output logic sense_short_n,
    output logic sleep_mode,
    output logic irq
);
    cal_state_t state_reg;
    logic [7:0] ctrl_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic [31:0] timer_reg;
    logic [31:0] avg_timer_reg;
    logic signed [31:0] avg_sum_reg;
    logic signed [15:0] current_reg;
    logic signed [63:0] charge_reg;
    logic signed [15:0] offset_reg;
    logic signed [15:0] ext_offset_reg;
    logic signed [15:0] ext_meas_reg;
    logic [31:0] capacity_reg;
    logic [15:0] tte_reg [4];
    logic quick_done_reg;
    logic shortcut_reg;
    logic [7:0] load_class_reg;
    logic [1:0] line_a_sync_reg;
    logic [1:0] line_b_sync_reg;
    logic [31:0] low_count_reg;
    logic [31:0] acc_window;
    logic calib_active;
    logic signed [15:0] corrected;
    logic [31:0] read_next;
    logic lines_low;
    logic [2:0] irq_event;
    logic [2:0] flags;
    sample_acc_if acc_bus ();

    window_accumulator u_acc (
        .clock(clock),
        .reset(reset),
        .window_ticks(acc_window),
        .acc(acc_bus)
    );

    function automatic logic signed [15:0] window_mean(input logic signed [31:0] sum,
                                                        input logic [31:0] ticks);
        window_mean = 16'(sum / $signed(ticks));
    endfunction

    function automatic logic [15:0] minutes_left(input logic [31:0] cap,
                                                  input logic [15:0] load);
        minutes_left = (load == 16'h0) ? 16'hffff : 16'(cap / {16'h0, load});
    endfunction

    // register decode shared by the write side and the clear-on-read side
    function automatic logic write_hit(input logic [7:0] target);
        write_hit = write_strobe && (address == target);
    endfunction

    function automatic logic read_hit(input logic [7:0] target);
        read_hit = read_strobe && (address == target);
    endfunction

    assign calib_active = (state_reg != CAL_IDLE) && (state_reg != CAL_DEFER);
    assign corrected = 16'($signed(sense_sample) - offset_reg - ext_offset_reg);
    assign acc_window = (state_reg == CAL_SETTLE || state_reg == CAL_QUICK) ?
                        QUICK_TICKS : WINDOW_TICKS;
    assign acc_bus.sample = $signed(sense_sample);
    assign sense_short_n = !calib_active;
    assign irq = |(irq_status_reg & irq_mask_reg);
    assign lines_low = !line_a_sync_reg[1] && !line_b_sync_reg[1];
    // events that set the sticky status bits
    assign irq_event[`IRQ_CAL_DONE_BIT] = (state_reg == CAL_FULL) && acc_bus.done;
    assign irq_event[`IRQ_SLEEP_BIT] = !sleep_mode && (low_count_reg == SLEEP_TICKS);
    assign irq_event[`IRQ_EXT_DONE_BIT] = (state_reg == CAL_EXT) && acc_bus.done;
    assign flags[`FLAG_CAL_BUSY_BIT] = calib_active;
    assign flags[`FLAG_SLEEP_BIT] = sleep_mode;
    assign flags[`FLAG_QUICK_DONE_BIT] = quick_done_reg;

    // synchronisers start high, so leaving reset does not look like lines held low
    always_ff @(posedge clock) begin
        if (reset) begin
            line_a_sync_reg <= 2'h3;
            line_b_sync_reg <= 2'h3;
        end else begin
            line_a_sync_reg <= {line_a_sync_reg[0], comm_line_a};
            line_b_sync_reg <= {line_b_sync_reg[0], comm_line_b};
        end
    end

    // both lines low long enough means the host is gone
    always_ff @(posedge clock) begin
        if (reset) begin
            low_count_reg <= 32'h0;
            sleep_mode <= 1'b0;
        end else if (!lines_low) begin
            low_count_reg <= 32'h0;
            sleep_mode <= 1'b0;
        end else if (low_count_reg == SLEEP_TICKS) begin
            sleep_mode <= 1'b1;
        end else begin
            low_count_reg <= low_count_reg + 32'h1;
        end
    end

    // calibration sequence; the accumulator measures the shorted input
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= CAL_SETTLE;
            timer_reg <= 32'h0;
            offset_reg <= 16'sh0;
            ext_meas_reg <= 16'sh0;
            quick_done_reg <= 1'b0;
            acc_bus.start <= 1'b1;
            load_class_reg <= 8'h0;
        end else begin
            acc_bus.start <= 1'b0;
            case (state_reg)
                CAL_SETTLE: begin
                    if (acc_bus.done) begin
                        if (shortcut_reg) begin
                            offset_reg <= window_mean(acc_bus.sum, QUICK_TICKS);
                            quick_done_reg <= 1'b1;
                            state_reg <= CAL_DEFER;
                            timer_reg <= 32'h0;
                        end else begin
                            state_reg <= CAL_QUICK;
                            acc_bus.start <= 1'b1;
                        end
                    end
                end
                CAL_QUICK: begin
                    if (acc_bus.done) begin
                        offset_reg <= window_mean(acc_bus.sum, QUICK_TICKS);
                        quick_done_reg <= 1'b1;
                        state_reg <= CAL_DEFER;
                        timer_reg <= 32'h0;
                    end
                end
                CAL_DEFER: begin
                    if (timer_reg == DEFER_TICKS) begin
                        state_reg <= CAL_FULL;
                        acc_bus.start <= 1'b1;
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                CAL_IDLE: begin
                    // a change of load class stands for changed operating conditions
                    if (load_class != load_class_reg || ctrl_reg[`CTRL_RECAL_BIT]) begin
                        load_class_reg <= load_class;
                        state_reg <= CAL_FULL;
                        acc_bus.start <= 1'b1;
                    end else if (ctrl_reg[`CTRL_EXT_MEAS_BIT]) begin
                        state_reg <= CAL_EXT;
                        acc_bus.start <= 1'b1;
                    end
                end
                CAL_FULL: begin
                    if (acc_bus.done) begin
                        offset_reg <= window_mean(acc_bus.sum, WINDOW_TICKS);
                        state_reg <= CAL_IDLE;
                    end
                end
                CAL_EXT: begin
                    if (acc_bus.done) begin
                        ext_meas_reg <= 16'(window_mean(acc_bus.sum, WINDOW_TICKS) -
                                            offset_reg);
                        state_reg <= CAL_IDLE;
                    end
                end
                default: state_reg <= CAL_IDLE;
            endcase
        end
    end

    // charge integration never stops, calibration included
    always_ff @(posedge clock) begin
        if (reset) begin
            charge_reg <= 64'sh0;
        end else if (sample_valid) begin
            charge_reg <= charge_reg + 64'(corrected);
        end
    end

    // capacity keeps following the charge through a full calibration
    always_ff @(posedge clock) begin
        if (reset) begin
            capacity_reg <= 32'h0;
        end else begin
            capacity_reg <= 32'((charge_reg < 0 ? -charge_reg : charge_reg) /
                                64'(`CAP_STEP_COUNTS));
        end
    end

    // 5.12 s current average; held while a full calibration runs
    always_ff @(posedge clock) begin
        if (reset) begin
            avg_timer_reg <= 32'h0;
            avg_sum_reg <= 32'sh0;
            current_reg <= 16'sh0;
        end else if (avg_timer_reg == WINDOW_TICKS - 1) begin
            avg_timer_reg <= 32'h0;
            avg_sum_reg <= 32'sh0;
            if (!calib_active) begin
                current_reg <= window_mean(avg_sum_reg, WINDOW_TICKS);
            end
        end else begin
            avg_timer_reg <= avg_timer_reg + 32'h1;
            avg_sum_reg <= avg_sum_reg + 32'(corrected);
        end
    end

    // time to empty for standby, peak, actual and at-rate loads
    generate
        for (genvar i = 0; i < 4; i++) begin : g_tte
            logic [15:0] load;
            assign load = (i == 0) ? standby_current :
                          (i == 1) ? peak_current :
                          (i == 2) ? 16'(current_reg < 0 ? -current_reg : current_reg) :
                          at_rate_current;
            always_ff @(posedge clock) begin
                if (reset) begin
                    tte_reg[i] <= 16'hffff;
                end else if (!calib_active) begin
                    tte_reg[i] <= 16'(minutes_left(capacity_reg, load) /
                                      `TTE_DIV_SAMPLES);
                end
            end
        end
    endgenerate

    // control register; recalibrate is a one-cycle request, measure waits for idle
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (write_hit(`ADDR_DEVICE_CONTROL)) begin
            ctrl_reg <= write_data[7:0];
        end else begin
            ctrl_reg[`CTRL_RECAL_BIT] <= 1'b0;
            if (state_reg == CAL_IDLE) begin
                ctrl_reg[`CTRL_EXT_MEAS_BIT] <= 1'b0;
            end
        end
    end

    // the shortcut only counts inside the settling window; later writes change nothing
    always_ff @(posedge clock) begin
        if (reset) begin
            shortcut_reg <= 1'b0;
        end else if (write_hit(`ADDR_DEVICE_CONTROL) && write_data[`CTRL_QUICK_BIT] &&
                     state_reg == CAL_SETTLE) begin
            shortcut_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ext_offset_reg <= 16'sh0;
        end else if (write_hit(`ADDR_EXT_OFFSET)) begin
            ext_offset_reg <= write_data[15:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irq_mask_reg <= 3'h0;
        end else if (write_hit(`ADDR_IRQ_MASK)) begin
            irq_mask_reg <= write_data[2:0];
        end
    end

    // sticky events; an event in the clearing read's cycle survives
    always_ff @(posedge clock) begin
        if (reset) begin
            irq_status_reg <= 3'h0;
        end else begin
            irq_status_reg <= (read_hit(`ADDR_IRQ_STATUS) ? 3'h0 : irq_status_reg) | irq_event;
        end
    end

    always_comb begin
        read_next = 32'h0;
        case (address)
            `ADDR_DEVICE_CONTROL: read_next = {24'h0, ctrl_reg};
            `ADDR_STATUS_FLAGS: read_next = {29'h0, flags};
            `ADDR_IRQ_STATUS: read_next = {29'h0, irq_status_reg};
            `ADDR_IRQ_MASK: read_next = {29'h0, irq_mask_reg};
            `ADDR_CURRENT_AVG: read_next = 32'(current_reg);
            `ADDR_CHARGE_LO: read_next = charge_reg[31:0];
            `ADDR_CHARGE_HI: read_next = charge_reg[63:32];
            `ADDR_OFFSET: read_next = {16'h0, offset_reg};
            `ADDR_EXT_OFFSET: read_next = {ext_meas_reg, ext_offset_reg};
            `ADDR_CAPACITY: read_next = capacity_reg;
            `ADDR_TTE_BASE: read_next = {16'h0, tte_reg[0]};
            `ADDR_TTE_BASE + 8'h04: read_next = {16'h0, tte_reg[1]};
            `ADDR_TTE_BASE + 8'h08: read_next = {16'h0, tte_reg[2]};
            `ADDR_TTE_BASE + 8'h0c: read_next = {16'h0, tte_reg[3]};
            default: read_next = 32'h0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            read_data <= 32'h0;
        end else begin
            read_data <= read_strobe ? read_next : 32'h0;
        end
    end
endmodule // offset_cal_sequencer

// ==== tb/offset_cal_sequencer_props.sv ====
// port assertions for the offset calibration sequencer
`timescale 1ns/100ps
module offset_cal_sequencer_props
    import gauge_cal_pkg::*;
#(
    parameter int unsigned WINDOW_TICKS = 40,
    parameter int unsigned QUICK_TICKS = 20,
    parameter int unsigned DEFER_TICKS = 100,
    parameter int unsigned SLEEP_TICKS = 10
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [31:0] read_data,
    input wire logic [7:0] load_class,
    input wire logic comm_line_a,
    input wire logic comm_line_b,
    input wire logic sense_short_n,
    input wire logic sleep_mode
);
    logic [15:0] count_reg;
    logic [15:0] low_reg;
    logic early_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // cycles since reset release, saturating so late checks stay quiet
    always_ff @(posedge clock) begin
        if (reset) count_reg <= 16'h0000;
        else if (count_reg != 16'hffff) count_reg <= count_reg + 16'h0001;
    end
    always_ff @(posedge clock) begin
        if (reset || comm_line_a || comm_line_b) low_reg <= 16'h0000;
        else if (low_reg != 16'hffff) low_reg <= low_reg + 16'h0001;
    end
    always_ff @(posedge clock) begin
        if (reset) early_reg <= 1'b0;
        else if (write_strobe && address == 8'h00 && write_data[0] && count_reg < QUICK_TICKS - 2)
            early_reg <= 1'b1;
    end
    sequence s_flags_read;
        read_strobe && address == 8'h04;
    endsequence
    a_cal_flag_mirror: assert property (s_flags_read |=>
        read_data[0] == !$past(sense_short_n))
        else $error("calibration flag disagrees with shorted input");
    a_settle_shorted: assert property (count_reg < QUICK_TICKS - 1 |-> !sense_short_n)
        else $error("input not shorted during settling sample");
    a_late_bit_ignored: assert property (!early_reg && count_reg > QUICK_TICKS + 2
        && count_reg < 2 * QUICK_TICKS - 2 |-> !sense_short_n)
        else $error("quick calibration ended early without shortcut");
    a_shortcut_halves: assert property (early_reg && count_reg > QUICK_TICKS + 3
        && count_reg < 2 * QUICK_TICKS |-> sense_short_n)
        else $error("shortcut did not halve quick calibration");
    a_full_deferred: assert property (count_reg > 2 * QUICK_TICKS + 3
        && count_reg < QUICK_TICKS + DEFER_TICKS - 2 |-> sense_short_n)
        else $error("full calibration not deferred");
    a_recal_on_change: assert property ($changed(load_class) && sense_short_n
        && count_reg > 2 * QUICK_TICKS + DEFER_TICKS + WINDOW_TICKS + 4 |-> ##[1:4] !sense_short_n)
        else $error("condition change did not start calibration");
    a_sleep_entry: assert property (low_reg == SLEEP_TICKS + 6 |-> sleep_mode)
        else $error("sleep not entered with lines low");
    a_sleep_cause: assert property ($rose(sleep_mode) |-> low_reg >= SLEEP_TICKS)
        else $error("sleep entered too soon");
endmodule // offset_cal_sequencer_props
bind offset_cal_sequencer offset_cal_sequencer_props #(.WINDOW_TICKS(WINDOW_TICKS),
    .QUICK_TICKS(QUICK_TICKS), .DEFER_TICKS(DEFER_TICKS), .SLEEP_TICKS(SLEEP_TICKS))
    u_offset_cal_sequencer_props (.clock(clock), .reset(reset), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .load_class(load_class), .comm_line_a(comm_line_a),
    .comm_line_b(comm_line_b), .sense_short_n(sense_short_n), .sleep_mode(sleep_mode));

// ==== tb/sense_front_end.sv ====
// behavioural model of the analog sense front end and the communication lines
`timescale 1ns/100ps
module sense_front_end (
    input wire logic clock,
    input wire logic reset,
    input wire logic sense_short_n,
    input wire logic lines_released,
    output logic [15:0] sense_sample,
    output logic sample_valid,
    output logic comm_line_a,
    output logic comm_line_b
);
    // shorted input still shows the internal offset, so calibration has something to remove
    always_ff @(posedge clock) begin
        if (reset) begin
            sample_valid <= 1'b0;
            sense_sample <= 16'h0003;
        end else begin
            sample_valid <= 1'b1;
            sense_sample <= sense_short_n ? 16'h0067 : 16'h0003;
        end
    end
    // released lines fall to the internal pull-down
    assign comm_line_a = !lines_released;
    assign comm_line_b = !lines_released;
endmodule // sense_front_end

// ==== tb/tb_top.sv ====
// self-checking bench for the offset calibration sequencer
`timescale 1ns/100ps
module tb_top;
    localparam int unsigned Q = 20;
    localparam int unsigned W = 40;
    localparam int unsigned D = 100;
    logic clock, reset, write_strobe, read_strobe, sample_valid, comm_line_a, comm_line_b;
    logic sense_short_n, sleep_mode, irq, lines_released;
    logic [7:0] address, load_class;
    logic [31:0] write_data, read_data, v, w;
    logic [15:0] sense_sample, standby_current, peak_current, at_rate_current;
    int fail_count, samples_checked, n;
    offset_cal_sequencer #(.WINDOW_TICKS(W), .QUICK_TICKS(Q), .DEFER_TICKS(D), .SLEEP_TICKS(10))
        u_offset_cal_sequencer (.clock(clock), .reset(reset), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .sense_sample(sense_sample), .sample_valid(sample_valid),
        .load_class(load_class), .standby_current(standby_current), .peak_current(peak_current),
        .at_rate_current(at_rate_current), .comm_line_a(comm_line_a), .comm_line_b(comm_line_b),
        .sense_short_n(sense_short_n), .sleep_mode(sleep_mode), .irq(irq));
    sense_front_end u_sense_front_end (.clock(clock), .reset(reset), .sense_short_n(sense_short_n),
        .lines_released(lines_released), .sense_sample(sense_sample), .sample_valid(sample_valid),
        .comm_line_a(comm_line_a), .comm_line_b(comm_line_b));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic final_report;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 d = read_data;
    endtask
    // every wait is bounded; running out ends the run as a mismatch
    task automatic wait_short(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (sense_short_n !== lvl) begin
            @(posedge clock);
            #1 cnt++;
            if (cnt > lim) begin
                check("wait bound", 32'h0, 32'h1);
                final_report;
            end
        end
    endtask
    task automatic do_reset;
        reset <= 1'b1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
    endtask
    initial begin
        {reset, write_strobe, read_strobe, lines_released} = 4'h8;
        {address, load_class, write_data} = '0;
        {fail_count, samples_checked} = '0;
        standby_current = 16'h0010;
        peak_current = 16'h0100;
        at_rate_current = 16'h0040;
        do_reset;
        rd(8'h04, v);
        check("flags settle", v & 32'h1, 32'h1);
        wr(8'h00, 32'h1);
        wait_short(1'b1, 3 * Q, n);
        check("shortcut quick", n < Q + 2, 32'h1);
        rd(8'h04, v);
        check("flags after quick", v & 32'h5, 32'h4);
        do_reset;
        repeat (Q + 3) @(posedge clock);
        wr(8'h00, 32'h1);
        wait_short(1'b1, 3 * Q, n);
        check("late shortcut", n > 4, 32'h1);
        wait_short(1'b0, 2 * D, n);
        check("full deferral", n > D - 3 && n < D + 3, 32'h1);
        rd(8'h10, v);
        rd(8'h04, w);
        check("flags full", w & 32'h1, 32'h1);
        check("irq masked", irq, 32'h0);
        wait_short(1'b1, W + 20, n);
        check("full length", n > W - 12, 32'h1);
        // an average window closes inside the calibration, so a live value would have moved
        rd(8'h10, w);
        check("current frozen", w, v);
        wr(8'h0c, 32'h1);
        @(posedge clock);
        #1 check("irq raised", irq, 32'h1);
        rd(8'h08, v);
        check("irq status", v, 32'h1);
        check("irq cleared", irq, 32'h0);
        rd(8'h08, v);
        check("irq status clear", v, 32'h0);
        rd(8'h14, v);
        repeat (4) @(posedge clock);
        rd(8'h14, w);
        check("charge moves", w != v, 32'h1);
        @(posedge clock);
        load_class <= 8'h01;
        wait_short(1'b0, 8, n);
        wait_short(1'b1, W + 20, n);
        rd(8'h08, v);
        check("recal done", v, 32'h1);
        wr(8'h0c, 32'h7);
        wr(8'h20, 32'h5);
        rd(8'h20, v);
        check("ext offset", v & 32'hffff, 32'h5);
        wr(8'h00, 32'h2);
        v = '0;
        for (n = 0; v[2] !== 1'b1; n++) begin
            rd(8'h08, v);
            if (n > 100) begin
                check("ext measure bound", 32'h0, 32'h1);
                final_report;
            end
        end
        wr(8'h40, 32'hff);
        rd(8'h40, v);
        check("unmapped read", v, 32'h0);
        @(posedge clock);
        lines_released <= 1'b1;
        for (n = 0; sleep_mode !== 1'b1; n++) begin
            @(posedge clock);
            #1;
            if (n > 40) begin
                check("sleep bound", 32'h0, 32'h1);
                final_report;
            end
        end
        rd(8'h08, v);
        check("sleep event", v & 32'h2, 32'h2);
        final_report;
    end
endmodule // tb_top
